// ---- src/acs_defines.vh ----
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ****************************************************************
// clock path
// ****************************************************************
`define ACS_DIV_RATIO 58
`define ACS_DIV_HALF 29
`define ACS_SYS_CLK_HZ 40000000
// highest internal clock for reliable conversion: 245.8 kHz, in 0.1 kHz units
`define ACS_MAX_INT_CLK_DKHZ 2458
// least internal clock period in system cycles, rounded up
`define ACS_MIN_PERIOD_CYC ((`ACS_SYS_CLK_HZ + `ACS_MAX_INT_CLK_DKHZ * 100 - 1) / (`ACS_MAX_INT_CLK_DKHZ * 100))

// ****************************************************************
// conversion sequence, in internal clock periods
// ****************************************************************
`define ACS_AZ_COUNT 1024
`define ACS_INTEG_COUNT 2048
`define ACS_FULL_SCALE 4096

// ****************************************************************
// three-level test input coding
// ****************************************************************
`define ACS_TEST_GND 2'h0
`define ACS_TEST_MID 2'h1
`define ACS_TEST_VPLUS 2'h2

`endif

// ---- src/acs_clock_counter.v ----
`timescale 1ns/1ps
`include "acs_defines.vh"

// Overview of operation
// (RL1) select input high or open selects the undivided RC clock path
// (RL2) RC path: internal clock follows buffered_osc_out, same frequency and phase
// (RL3) select low: buffered oscillator passes a fixed divide-by-58 prescaler
// (RL4) overdriven with select high: internal clock copies input duty, frequency, phase
// (RL5) signal integration lasts exactly 2048 internal clock periods
// (RL6) internal clock up to 245.8 kHz, thirty conversions per second, is supported
// (RL7) test at ground stops internal clock and forces all counter outputs high
// (RL8) after test leaves ground, first clock drives all counter outputs low; the code clears the count but not the sign flag
// (RL9) test at mid level makes the live counter visible on the outputs
// (RL10) full scale is 4096 counts, input twice the reference
// (RL11) result is twelve bits, sign and overrange; upper byte holds bits 9-12
// (RL12) prescaler is a modulo-58 counter with an even duty cycle
module acs_clock_counter #(
  parameter AZ_COUNT = `ACS_AZ_COUNT,
  parameter INTEG_COUNT = `ACS_INTEG_COUNT
) (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // oscillator pins
  input wire buffered_osc_out_i,
  input wire osc_select_i,
  // three-level test pin, coded
  input wire [1:0] test_level_i,
  // analog comparator pins
  input wire zero_cross_i,
  input wire polarity_i,
  // clock and phase outputs
  output reg int_clk_o,
  output reg integrate_o,
  output reg deint_o,
  output reg status_o,
  output reg overspeed_o,
  // result outputs
  output reg [11:0] count_o,
  output reg sign_flag_o,
  output reg overrange_o,
  output reg [7:0] low_byte_o,
  output reg [7:0] high_byte_o
);

  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  localparam ST_AZ = 3'h1;
  localparam ST_INT = 3'h2;
  localparam ST_DE = 3'h4;
  // integer forms first, then cut to the widths the logic compares against
  localparam integer MIN_PER_I = `ACS_MIN_PERIOD_CYC;
  localparam integer FULL_I = `ACS_FULL_SCALE;
  localparam integer INT_LAST_I = INTEG_COUNT - 1;
  localparam integer AZ_LAST_I = AZ_COUNT - 1;
  localparam integer DIV_LAST_I = `ACS_DIV_RATIO - 1;
  localparam integer DIV_HALF_I = `ACS_DIV_HALF;
  localparam [7:0] MIN_PER = MIN_PER_I[7:0];
  localparam [12:0] FULL = FULL_I[12:0];
  localparam [12:0] INT_LAST = INT_LAST_I[12:0];
  localparam [12:0] AZ_LAST = AZ_LAST_I[12:0];
  localparam [5:0] DIV_LAST = DIV_LAST_I[5:0];
  localparam [5:0] DIV_HALF = DIV_HALF_I[5:0];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;

  // two flip-flops on every pin input
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 6'h0a; // select as if pulled up, test at V+
      sync2_reg <= 6'h0a;
    end else if (ce_i) begin
      sync1_reg <= {polarity_i, zero_cross_i, test_level_i, osc_select_i, buffered_osc_out_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire osc_s = sync2_reg[0];
  wire sel_s = sync2_reg[1];
  wire [1:0] test_s = sync2_reg[3:2];
  wire zc_s = sync2_reg[4];
  wire pol_s = sync2_reg[5];
  wire test_gnd = (test_s == `ACS_TEST_GND);
  wire test_mid = (test_s == `ACS_TEST_MID);

  // ****************************************************************
  // clock selection and prescaler
  // ****************************************************************
  reg osc_d_reg;
  reg [5:0] div_reg;
  reg [5:0] div_next;
  reg div_clk_reg;
  reg div_clk_next;
  reg clk_sel;

  // edge detect on the synchronised oscillator
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_d_reg <= 1'b0;
    end else if (ce_i) begin
      osc_d_reg <= osc_s;
    end
  end

  wire osc_rise = osc_s & ~osc_d_reg;

  // modulo-58 counter, high for the first half of each period
  always @* begin
    div_next = div_reg;
    div_clk_next = div_clk_reg;
    if (osc_rise) begin
      if (div_reg == DIV_LAST) begin // RL12
        div_next = 6'h00;
      end else begin
        div_next = div_reg + 6'h01;
      end
      div_clk_next = (div_next < DIV_HALF); // RL3 RL12
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 6'h00;
      div_clk_reg <= 1'b0;
    end else if (ce_i) begin
      div_reg <= div_next;
      div_clk_reg <= div_clk_next;
    end
  end

  // path select: high picks the undivided oscillator
  always @* begin
    if (sel_s) begin
      clk_sel = osc_s; // RL1 RL2 RL4
    end else begin
      clk_sel = div_clk_reg; // RL3
    end
  end

  // ****************************************************************
  // gated internal clock and tick
  // ****************************************************************
  reg int_clk_reg;
  wire int_clk_next = test_gnd ? int_clk_reg : clk_sel; // RL7
  wire tick = int_clk_next & ~int_clk_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_clk_reg <= 1'b0;
    end else if (ce_i) begin
      int_clk_reg <= int_clk_next;
    end
  end

  // ****************************************************************
  // clock rate monitor
  // ****************************************************************
  reg [7:0] per_reg;
  reg fast_reg;

  // flags internal clock periods shorter than the supported rate
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_reg <= 8'hff; // no period seen yet, so no false flag on the first tick
      fast_reg <= 1'b0;
    end else if (ce_i) begin
      if (tick) begin
        per_reg <= 8'h00;
        if (per_reg < MIN_PER - 8'h01) begin // per_reg holds period minus one
          fast_reg <= 1'b1; // RL6
        end else begin
          fast_reg <= 1'b0;
        end
      end else if (per_reg != 8'hff) begin
        per_reg <= per_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // conversion sequencer and counter
  // ****************************************************************
  reg [2:0] state_reg;
  reg [12:0] cnt_reg;
  reg clr_pend_reg;
  reg sign_reg;
  reg [11:0] res_reg;
  reg res_sign_reg;
  reg res_or_reg;
  reg done_reg;

  // counter with test preset and phase sequencing
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_AZ;
      cnt_reg <= 13'h0000;
      clr_pend_reg <= 1'b0;
      sign_reg <= 1'b0;
      res_reg <= 12'h000;
      res_sign_reg <= 1'b0;
      res_or_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      done_reg <= 1'b0;
      if (test_gnd) begin
        cnt_reg <= 13'h0fff; // RL7
        clr_pend_reg <= 1'b1;
        state_reg <= ST_AZ;
      end else if (tick) begin
        if (clr_pend_reg) begin
          cnt_reg <= 13'h0000; // RL8
          clr_pend_reg <= 1'b0;
        end else begin
          case (state_reg)
            ST_AZ: begin
              if (cnt_reg == AZ_LAST) begin
                cnt_reg <= 13'h0000;
                state_reg <= ST_INT;
              end else begin
                cnt_reg <= cnt_reg + 13'h0001;
              end
            end
            ST_INT: begin
              if (cnt_reg == INT_LAST) begin // RL5
                cnt_reg <= 13'h0000;
                sign_reg <= pol_s;
                state_reg <= ST_DE;
              end else begin
                cnt_reg <= cnt_reg + 13'h0001;
              end
            end
            ST_DE: begin
              if (zc_s || cnt_reg == FULL) begin
                res_reg <= cnt_reg[11:0]; // RL10
                res_sign_reg <= sign_reg;
                res_or_reg <= (cnt_reg == FULL); // RL10
                done_reg <= 1'b1;
                cnt_reg <= 13'h0000;
                state_reg <= ST_AZ;
              end else begin
                cnt_reg <= cnt_reg + 13'h0001;
              end
            end
            default: begin
              cnt_reg <= 13'h0000;
              state_reg <= ST_AZ;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  reg [11:0] view;
  reg view_sign;
  reg view_or;

  // live counter when test is mid or ground, else latched result
  always @* begin
    if (test_mid || test_gnd) begin
      view = cnt_reg[11:0]; // RL9
      view_sign = sign_reg;
      view_or = cnt_reg[12];
    end else begin
      view = res_reg;
      view_sign = res_sign_reg;
      view_or = res_or_reg;
    end
    if (test_gnd) begin
      view_sign = 1'b1; // RL7
      view_or = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_clk_o <= 1'b0;
      integrate_o <= 1'b0;
      deint_o <= 1'b0;
      status_o <= 1'b0;
      overspeed_o <= 1'b0;
      count_o <= 12'h000;
      sign_flag_o <= 1'b0;
      overrange_o <= 1'b0;
      low_byte_o <= 8'h00;
      high_byte_o <= 8'h00;
    end else if (ce_i) begin
      int_clk_o <= int_clk_reg;
      integrate_o <= (state_reg == ST_INT);
      deint_o <= (state_reg == ST_DE);
      status_o <= (state_reg != ST_AZ) & ~done_reg;
      overspeed_o <= fast_reg;
      count_o <= view;
      sign_flag_o <= view_sign;
      overrange_o <= view_or;
      low_byte_o <= view[7:0]; // RL11
      high_byte_o <= {2'h0, view_or, view_sign, view[11:8]}; // RL11
    end
  end

endmodule

// ---- testbench/acs_osc_src.sv ----
`timescale 1ns/1ps
// ****
// oscillator source
// ****
module acs_osc_src (
  input wire sys_clk_i,
  input wire [3:0] hi_i,
  input wire [3:0] lo_i,
  output logic osc_o
);
  logic [3:0] cnt_reg = 4'h0;
  // runs free: hi_i cycles high, lo_i cycles low
  initial osc_o = 1'h0;
  always @(posedge sys_clk_i) begin
    if (cnt_reg + 4'h1 >= (osc_o ? hi_i : lo_i)) begin
      cnt_reg <= 4'h0;
      osc_o <= ~osc_o;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// ---- testbench/acs_props.sv ----
`timescale 1ns/1ps
// ****
// checker
// ****
module acs_props #(parameter INTEG_COUNT = 2048) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire buffered_osc_out_i,
  input wire osc_select_i,
  input wire [1:0] test_level_i,
  input wire int_clk_o,
  input wire integrate_o,
  input wire deint_o,
  input wire [11:0] count_o,
  input wire sign_flag_o,
  input wire overrange_o,
  input wire [7:0] low_byte_o,
  input wire [7:0] high_byte_o
);
  reg os_reg, ck_reg, sl_reg;
  reg [7:0] rs_reg;
  reg [31:0] run_reg, pc_reg, pl_reg, in_reg;
  wire tog = int_clk_o != ck_reg;
  wire up = int_clk_o & ~ck_reg;
  // osc rises per phase, steady run, clock period, integrate length
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      os_reg <= 1'h0;
      ck_reg <= 1'h0;
      sl_reg <= 1'h0;
      rs_reg <= 8'h00;
      run_reg <= 32'h0;
      pc_reg <= 32'h0;
      pl_reg <= 32'h0;
      in_reg <= 32'h0;
    end else begin
      os_reg <= buffered_osc_out_i;
      ck_reg <= int_clk_o;
      sl_reg <= osc_select_i;
      rs_reg <= tog ? 8'h00 : rs_reg + {7'h00, buffered_osc_out_i & ~os_reg};
      run_reg <= (!ce_i || test_level_i == 2'h0 || osc_select_i != sl_reg) ? 32'h0 : run_reg + {31'h0, tog};
      pc_reg <= up ? 32'h1 : pc_reg + 32'h1;
      pl_reg <= up ? pc_reg : pl_reg;
      in_reg <= integrate_o ? in_reg + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  rc_follow_a: assert property ((ce_i && osc_select_i && test_level_i != 2'h0)[*8] ##0 $rose(int_clk_o)
    |-> $past(buffered_osc_out_i, 4) || $past(buffered_osc_out_i, 5)) else $error("rc clock");
  div_ratio_a: assert property (tog && !osc_select_i && run_reg >= 32'h4 |-> rs_reg == 8'h1d)
    else $error("divide ratio");
  integ_len_a: assert property ($fell(integrate_o) && run_reg > 2 * INTEG_COUNT + 4
    |-> in_reg == INTEG_COUNT * pl_reg) else $error("integrate length");
  gnd_force_a: assert property ((test_level_i == 2'h0 && ce_i)[*6]
    |-> count_o == 12'hfff && sign_flag_o && overrange_o) else $error("test force");
  gnd_stop_a: assert property ((test_level_i == 2'h0 && ce_i)[*7] |-> $stable(int_clk_o)) else $error("stop");
  clear_first_a: assert property ($rose(int_clk_o) && test_level_i == 2'h1 && $past(count_o) == 12'hfff
    |-> ##[1:3] count_o == 12'h000) else $error("test clear");
  phase_excl_a: assert property (!(integrate_o && deint_o)) else $error("phase overlap");
  byte_map_a: assert property ((test_level_i == 2'h2 && $stable({count_o, sign_flag_o, overrange_o}))[*3]
    |-> low_byte_o == count_o[7:0] && high_byte_o == {2'h0, overrange_o, sign_flag_o, count_o[11:8]})
    else $error("byte map");
endmodule
bind acs_clock_counter acs_props #(.INTEG_COUNT(INTEG_COUNT)) u_acs_props (.*);

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
// ****
// bench
// ****
module tb;
  logic sys_clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, osc_select_i = 1'h1;
  logic zero_cross_i = 1'h0, polarity_i = 1'h0, sign_flag = 1'h0;
  logic [1:0] test_level_i = 2'h2;
  logic [3:0] hi = 4'h4, lo = 4'h4;
  wire buffered_osc_out_i, int_clk_o, integrate_o, deint_o, status_o, overspeed_o, sign_flag_o, overrange_o;
  wire [11:0] count_o;
  wire [7:0] low_byte_o, high_byte_o;
  int err_count = 0, cmp_count = 0, cyc = 0, n, h;
  acs_osc_src u_acs_osc_src (.sys_clk_i(sys_clk_i), .hi_i(hi), .lo_i(lo), .osc_o(buffered_osc_out_i));
  acs_clock_counter #(.AZ_COUNT(4), .INTEG_COUNT(8)) u_acs_clock_counter (.*);
  // clock and watchdog
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end
  // expected internal clock high time or period in system cycles
  function automatic logic [31:0] exp_t(input int hh, input int ll, input bit dv, input bit full);
    return dv ? (full ? 58 : 29) * (hh + ll) : (full ? hh + ll : hh);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // measures one high phase and one period of the internal clock
  task clk_chk(input bit dv);
    @(posedge int_clk_o);
    @(negedge sys_clk_i);
    n = 0;
    while (int_clk_o === 1'h1) begin
      n++;
      @(negedge sys_clk_i);
    end
    h = n;
    while (int_clk_o === 1'h0) begin
      n++;
      @(negedge sys_clk_i);
    end
    chk(h, exp_t(hi, lo, dv, 1'h0));
    chk(n, exp_t(hi, lo, dv, 1'h1));
  endtask
  // new random oscillator shape and path, held still meanwhile
  task setosc(input bit sel);
    @(posedge sys_clk_i);
    ce_i <= 1'h0;
    osc_select_i <= sel;
    hi <= 4'($urandom_range(9, 4));
    lo <= 4'($urandom_range(9, 4));
    repeat (4) @(posedge sys_clk_i);
    ce_i <= 1'h1;
    repeat (2) @(posedge int_clk_o);
  endtask
  // main sequence
  initial begin
    void'($urandom(30));
    repeat (3) @(negedge sys_clk_i);
    chk({int_clk_o, integrate_o, status_o, count_o, low_byte_o, high_byte_o}, 32'h0);
    @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    clk_chk(1'h0);
    chk(overspeed_o, 1'h1);
    sign_flag = 1'($urandom);
    @(posedge sys_clk_i);
    polarity_i <= sign_flag;
    @(posedge integrate_o);
    @(negedge sys_clk_i);
    n = 0;
    while (integrate_o === 1'h1) begin
      n++;
      @(negedge sys_clk_i);
    end
    chk(n, 8 * exp_t(4, 4, 1'h0, 1'h1));
    chk(deint_o, 1'h1);
    @(negedge status_o);
    repeat (2) @(negedge sys_clk_i);
    chk({overrange_o, count_o}, 13'h1000);
    chk(sign_flag_o, sign_flag);
    chk({high_byte_o, low_byte_o}, {2'h0, 1'h1, sign_flag, 12'h000});
    @(posedge sys_clk_i);
    zero_cross_i <= 1'h1;
    setosc(1'h0);
    clk_chk(1'h1);
    chk(overspeed_o, 1'h0);
    setosc(1'h1);
    clk_chk(1'h0);
    chk(overspeed_o, 1'h1);
    @(posedge sys_clk_i);
    test_level_i <= 2'h0;
    repeat (8) @(negedge sys_clk_i);
    chk({sign_flag_o, overrange_o, count_o}, 14'h3fff);
    h = int_clk_o;
    repeat (40) @(negedge sys_clk_i);
    chk(int_clk_o, h);
    @(posedge sys_clk_i);
    test_level_i <= 2'h1;
    @(posedge int_clk_o);
    repeat (3) @(negedge sys_clk_i);
    chk(count_o, 12'h000);
    end_sim();
  end
endmodule
